//--- pcg_pkg.sv
// What this block does
// - Run gate one bit 0 clocks the async serial unit; clear stops it.
// - Run gate one bit 4 clocks the sync serial unit; clear stops it.
// - Run gate one bit 8 clocks the quadrature decoder; clear stops it.
// - Deep-sleep gate zero bit 3 clocks the watchdog; clear stops it.
// - Deep-sleep gate zero bit 20 clocks the PWM unit; clear stops it.
// - Deep-sleep gate zero bit 16 clocks converter zero; clear stops it.
// - Access to an unclocked peripheral is answered with a bus fault.
// - All gating enables reset to zero unless documented otherwise.
// - Run register gates while running; sleep and deep-sleep registers in those modes.
// - Sleep and deep-sleep registers act only when automatic gating is selected.
// - Bits beyond implemented units are read-only; writes have no effect.
// - Deep-sleep gate zero resets to a value with only bit 6 set.
package pcg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] PCG_OFS_RUN_GATE_ONE     = 12'h104;
    localparam logic [11:0] PCG_OFS_SLEEP_GATE_ONE   = 12'h114;
    localparam logic [11:0] PCG_OFS_DSLP_GATE_ONE    = 12'h124;
    localparam logic [11:0] PCG_OFS_DSLP_GATE_ZERO   = 12'h120;
    localparam logic [11:0] PCG_OFS_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [11:0] PCG_OFS_FAULT_STATUS     = 12'h200;
    localparam logic [11:0] PCG_OFS_FAULT_MASK       = 12'h204;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PCG_BIT_ASYNC_SERIAL = 0;
    localparam int PCG_BIT_SYNC_SERIAL  = 4;
    localparam int PCG_BIT_QUAD_DECODER = 8;
    localparam int PCG_BIT_WATCHDOG     = 3;
    localparam int PCG_BIT_CONVERTER    = 16;
    localparam int PCG_BIT_PWM          = 20;
    localparam int PCG_BIT_CAN_ZERO     = 24;
    localparam int PCG_BIT_AUTO_GATING  = 27;
    localparam int PCG_NUM_UNITS        = 7;

    // Writable masks and reset values.
    localparam logic [31:0] PCG_GATE_ONE_WMASK   = 32'h0000_0111;
    localparam logic [31:0] PCG_GATE_ZERO_WMASK  = 32'h0111_0008;
    localparam logic [31:0] PCG_CONFIG_WMASK     = 32'h0800_0000;
    localparam logic [31:0] PCG_GATE_ONE_RESET   = 32'h0000_0000;
    localparam logic [31:0] PCG_GATE_ZERO_RESET  = 32'h0000_0040;
    localparam logic [31:0] PCG_CONFIG_RESET     = 32'h0000_0000;
    localparam logic [PCG_NUM_UNITS-1:0] PCG_UNITS_RESET = 7'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCG_MODE_RUN,
        PCG_MODE_SLEEP,
        PCG_MODE_DEEP
    } pcg_mode_t;

    // Access from the processor to a gated peripheral.
    typedef struct packed {
        logic                     valid;
        logic [PCG_NUM_UNITS-1:0] unit_sel;
    } pcg_periph_req_t;

    typedef enum logic [1:0] {
        PCG_RESP_OKAY   = 2'b00,
        PCG_RESP_SLVERR = 2'b10
    } pcg_resp_t;

endpackage

//--- pcg_glitchfree_gate.sv
`timescale 1ns/10ps
// Latch-free clock gate: enable is retimed on the falling edge so it can only
// change while the clock is low, so no output pulse is ever shortened.
module pcg_glitchfree_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Gate control
    input  wire logic enable,
    // Gated clock and retimed enable
    output logic      gclk,
    output logic      active
);
    import pcg_pkg::*;

    logic en_neg_ff;

    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_neg_ff <= 1'b0;
        end else begin
            en_neg_ff <= enable;
        end
    end

    assign gclk   = clk & en_neg_ff;
    assign active = en_neg_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_GATE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        active == enable)
        else $error("gate enable not retimed by the falling edge");
endmodule

//--- pcg_clock_gating.sv
`timescale 1ns/10ps
module pcg_clock_gating (
    // System clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  nrst,
    // AXI4-Lite write address
    input  wire logic [11:0]                           s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                                 s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]                           s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                                s_axi_rdata,
    output logic [1:0]                                 s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready,
    // Power mode from the power controller
    input  wire pcg_pkg::pcg_mode_t                    power_mode,
    // Peripheral access check
    input  wire pcg_pkg::pcg_periph_req_t              periph_req,
    output logic                                       periph_fault,
    // Gated clocks and enables, order: async, sync, quad, wdog, conv, pwm, can
    output logic [pcg_pkg::PCG_NUM_UNITS-1:0]          unit_clk,
    output logic [pcg_pkg::PCG_NUM_UNITS-1:0]          unit_enable,
    // Interrupt
    output logic                                       irq
);
    import pcg_pkg::*;

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] run_gate_one_ff;
    logic [31:0] sleep_gate_one_ff;
    logic [31:0] dslp_gate_one_ff;
    logic [31:0] run_gate_zero_ff;
    logic [31:0] sleep_gate_zero_ff;
    logic [31:0] dslp_gate_zero_ff;
    logic [31:0] run_clock_config_ff;
    logic [PCG_NUM_UNITS-1:0] fault_status_ff;
    logic [PCG_NUM_UNITS-1:0] fault_mask_ff;

    // ------------------------------------------------------------------
    // AXI write path: address and data latched in either order
    // ------------------------------------------------------------------
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [11:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;

    wire         aw_take  = s_axi_awvalid & s_axi_awready;
    wire         w_take   = s_axi_wvalid & s_axi_wready;
    wire         wr_fire  = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire  [11:0] wr_word  = {aw_addr_ff[11:2], 2'b00};
    wire  [31:0] wr_bmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                             {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    function automatic logic addr_known(input logic [11:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        return (w == PCG_OFS_RUN_GATE_ONE) || (w == PCG_OFS_SLEEP_GATE_ONE) ||
               (w == PCG_OFS_DSLP_GATE_ONE) || (w == PCG_OFS_DSLP_GATE_ZERO) ||
               (w == PCG_OFS_RUN_CLOCK_CONFIG) || (w == PCG_OFS_FAULT_STATUS) ||
               (w == PCG_OFS_FAULT_MASK);
    endfunction

    // Only implemented enables change; reserved bits keep their reset value.
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] wmask);
        return (old_v & ~(wr_bmask & wmask)) | (w_data_ff & wr_bmask & wmask);
    endfunction

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            if (w_take) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= PCG_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= addr_known(aw_addr_ff) ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Register writes. Run gate zero and sleep gate zero live outside this
    // map; they stay at reset so their units idle in those modes.
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            run_gate_one_ff     <= PCG_GATE_ONE_RESET;
            sleep_gate_one_ff   <= PCG_GATE_ONE_RESET;
            dslp_gate_one_ff    <= PCG_GATE_ONE_RESET;
            run_gate_zero_ff    <= PCG_GATE_ZERO_RESET;
            sleep_gate_zero_ff  <= PCG_GATE_ZERO_RESET;
            dslp_gate_zero_ff   <= PCG_GATE_ZERO_RESET;
            run_clock_config_ff <= PCG_CONFIG_RESET;
            fault_mask_ff       <= PCG_UNITS_RESET;
        end else if (wr_fire) begin
            unique case (wr_word)
                PCG_OFS_RUN_GATE_ONE: begin
                    run_gate_one_ff <= merge(run_gate_one_ff, PCG_GATE_ONE_WMASK);
                end
                PCG_OFS_SLEEP_GATE_ONE: begin
                    sleep_gate_one_ff <= merge(sleep_gate_one_ff, PCG_GATE_ONE_WMASK);
                end
                PCG_OFS_DSLP_GATE_ONE: begin
                    dslp_gate_one_ff <= merge(dslp_gate_one_ff, PCG_GATE_ONE_WMASK);
                end
                PCG_OFS_DSLP_GATE_ZERO: begin
                    dslp_gate_zero_ff <= merge(dslp_gate_zero_ff, PCG_GATE_ZERO_WMASK);
                end
                PCG_OFS_RUN_CLOCK_CONFIG: begin
                    run_clock_config_ff <= merge(run_clock_config_ff, PCG_CONFIG_WMASK);
                end
                PCG_OFS_FAULT_MASK: begin
                    fault_mask_ff <= w_data_ff[PCG_NUM_UNITS-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI read path
    // ------------------------------------------------------------------
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rd_mux;

    wire  [11:0] rd_word = {s_axi_araddr[11:2], 2'b00};
    wire         ar_take = s_axi_arvalid & s_axi_arready;

    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (rd_word)
            PCG_OFS_RUN_GATE_ONE:     rd_mux = run_gate_one_ff;
            PCG_OFS_SLEEP_GATE_ONE:   rd_mux = sleep_gate_one_ff;
            PCG_OFS_DSLP_GATE_ONE:    rd_mux = dslp_gate_one_ff;
            PCG_OFS_DSLP_GATE_ZERO:   rd_mux = dslp_gate_zero_ff;
            PCG_OFS_RUN_CLOCK_CONFIG: rd_mux = run_clock_config_ff;
            PCG_OFS_FAULT_STATUS:     rd_mux = {25'h0000000, fault_status_ff};
            PCG_OFS_FAULT_MASK:       rd_mux = {25'h0000000, fault_mask_ff};
            default:                  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= PCG_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= addr_known(s_axi_araddr) ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Gate selection by power mode
    // ------------------------------------------------------------------
    wire auto_gating_select = run_clock_config_ff[PCG_BIT_AUTO_GATING];

    // Sleep and deep-sleep sets only apply with automatic gating on.
    wire use_sleep = auto_gating_select & (power_mode == PCG_MODE_SLEEP);
    wire use_deep  = auto_gating_select & (power_mode == PCG_MODE_DEEP);

    wire [31:0] sel_gate_one  = use_deep  ? dslp_gate_one_ff  :
                                use_sleep ? sleep_gate_one_ff : run_gate_one_ff;
    wire [31:0] sel_gate_zero = use_deep  ? dslp_gate_zero_ff :
                                use_sleep ? sleep_gate_zero_ff : run_gate_zero_ff;

    wire [PCG_NUM_UNITS-1:0] want_enable = {
        sel_gate_zero[PCG_BIT_CAN_ZERO],
        sel_gate_zero[PCG_BIT_PWM],
        sel_gate_zero[PCG_BIT_CONVERTER],
        sel_gate_zero[PCG_BIT_WATCHDOG],
        sel_gate_one[PCG_BIT_QUAD_DECODER],
        sel_gate_one[PCG_BIT_SYNC_SERIAL],
        sel_gate_one[PCG_BIT_ASYNC_SERIAL]
    };

    genvar g;
    generate
        for (g = 0; g < PCG_NUM_UNITS; g++) begin : gen_gate
            pcg_glitchfree_gate u_gate (
                .clk    (clk),
                .rst_n  (rst_n_ff),
                .enable (want_enable[g]),
                .gclk   (unit_clk[g]),
                .active (unit_enable[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Bus fault on access to an unclocked unit, with sticky status
    // ------------------------------------------------------------------
    wire [PCG_NUM_UNITS-1:0] fault_hit = {PCG_NUM_UNITS{periph_req.valid}} &
                                         periph_req.unit_sel & ~want_enable;
    wire [PCG_NUM_UNITS-1:0] fault_clr = (wr_fire && wr_word == PCG_OFS_FAULT_STATUS) ?
                                         (w_data_ff[PCG_NUM_UNITS-1:0]) : PCG_UNITS_RESET;
    wire [PCG_NUM_UNITS-1:0] fault_keep = fault_status_ff & ~fault_clr;

    assign periph_fault = |fault_hit;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fault_status_ff <= PCG_UNITS_RESET;
        end else begin
            // A new fault wins over a clear in the same cycle.
            fault_status_ff <= fault_keep | fault_hit;
        end
    end

    assign irq = |(fault_status_ff & fault_mask_ff);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_fault_seen;
        periph_req.valid && |(periph_req.unit_sel & ~want_enable);
    endsequence

    sequence s_status_set;
        (fault_status_ff & $past(fault_hit)) == $past(fault_hit);
    endsequence

    AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!rst_n_ff)
        s_fault_seen |-> periph_fault ##1 s_status_set)
        else $error("fault on unclocked unit not flagged");

    AST_NO_FAULT_WHEN_ON: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (periph_req.valid && (periph_req.unit_sel & ~want_enable) == 7'h00) |-> !periph_fault)
        else $error("fault raised for clocked unit");

    AST_ASYNC_ENABLE: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (!auto_gating_select && $rose(run_gate_one_ff[PCG_BIT_ASYNC_SERIAL]))
        |=> unit_enable[0])
        else $error("async serial clock not enabled");

    AST_SYNC_DISABLE: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (!auto_gating_select && !run_gate_one_ff[PCG_BIT_SYNC_SERIAL]) |-> !unit_enable[1])
        else $error("sync serial clock left running");

    AST_QUAD_TRACK: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !use_sleep && !use_deep |-> unit_enable[2] == run_gate_one_ff[PCG_BIT_QUAD_DECODER])
        else $error("quadrature decoder gate wrong in run mode");

    AST_DEEP_WDOG: assert property (@(posedge clk) disable iff (!rst_n_ff)
        use_deep |-> unit_enable[3] == dslp_gate_zero_ff[PCG_BIT_WATCHDOG])
        else $error("watchdog gate wrong in deep sleep");

    AST_DEEP_PWM_CONV: assert property (@(posedge clk) disable iff (!rst_n_ff)
        use_deep |-> unit_enable[5:4] ==
        {dslp_gate_zero_ff[PCG_BIT_PWM], dslp_gate_zero_ff[PCG_BIT_CONVERTER]})
        else $error("pwm or converter gate wrong in deep sleep");

    AST_RESERVED_FIXED: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (dslp_gate_zero_ff & ~PCG_GATE_ZERO_WMASK) == PCG_GATE_ZERO_RESET)
        else $error("reserved bits of deep-sleep gate zero changed");

    // The interrupt may only rise after a new fault or a register write.
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n_ff)
        $rose(irq) |-> ($past(periph_fault) || $past(wr_fire)))
        else $error("irq rose without a fault or a register write");

    AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (!rst_n_ff)
        1'b1 |=> (fault_status_ff & $past(fault_keep)) == $past(fault_keep))
        else $error("fault status bit lost without a clear");

    AST_SLEEP_SYNC: assert property (@(posedge clk) disable iff (!rst_n_ff)
        use_sleep |-> unit_enable[1] == sleep_gate_one_ff[PCG_BIT_SYNC_SERIAL])
        else $error("sync serial gate wrong in sleep");

    AST_DEEP_CAN: assert property (@(posedge clk) disable iff (!rst_n_ff)
        use_deep |-> unit_enable[6] == dslp_gate_zero_ff[PCG_BIT_CAN_ZERO])
        else $error("can gate wrong in deep sleep");
endmodule

//--- test_pcg_clock_gating.sv
`timescale 1ns/10ps
module test_pcg_clock_gating;
    import pcg_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic            clk = 1'b0;
    logic            nrst = 1'b0;
    logic [11:0]     awaddr = 12'h000, araddr = 12'h000;
    logic [31:0]     wdata = 32'h0000_0000;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic            awready, wready, bvalid, arready, rvalid, periph_fault, irq;
    logic [1:0]      bresp, rresp;
    logic [31:0]     rdata;
    logic [6:0]      unit_clk, unit_enable;
    pcg_mode_t       power_mode = PCG_MODE_RUN;
    pcg_periph_req_t periph_req = '0;
    int              miscompares = 0;
    int              checks = 0;
    logic [31:0]     rd;
    logic [1:0]      rsp;

    always #10 clk = ~clk;

    pcg_clock_gating dut (
        .clk(clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_mode(power_mode), .periph_req(periph_req), .periph_fault(periph_fault),
        .unit_clk(unit_clk), .unit_enable(unit_enable), .irq(irq)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Handshakes are judged on the falling edge, where the ready lines are already
    // settled for the coming rising edge, so no race with the design's flops arises.
    // Each transfer starts one edge on, so a strobe just dropped is not raised at once.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        @(posedge clk);
        b_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !b_ok; i++) begin
            @(negedge clk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
        end
        if (!b_ok) chk(32'h0, 32'h1);
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        @(posedge clk);
        r_ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !r_ok; i++) begin
            @(negedge clk);
            ar_ok = arvalid && arready;
            r_ok = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
        end
        if (!r_ok) chk(32'h0, 32'h1);
    endtask

    // Enables move on the falling edge; the gated clocks may only follow the clock.
    task automatic en_chk(input logic [6:0] e);
        @(negedge clk);
        #2 chk({25'h0, unit_enable}, {25'h0, e});
        @(posedge clk);
        #2 chk({25'h0, unit_clk}, {25'h0, e});
        @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_values();
        axi_rd(PCG_OFS_RUN_GATE_ONE, rd, rsp);
        chk(rd, 32'h0000_0000);
        chk({30'h0, rsp}, {30'h0, PCG_RESP_OKAY});
        axi_rd(PCG_OFS_DSLP_GATE_ZERO, rd, rsp);
        chk(rd, 32'h0000_0040);
        en_chk(7'h00);
    endtask

    task automatic test_run_gating();
        axi_wr(PCG_OFS_RUN_GATE_ONE, 32'hFFFF_FFFF, rsp);
        chk({30'h0, rsp}, {30'h0, PCG_RESP_OKAY});
        axi_rd(PCG_OFS_RUN_GATE_ONE, rd, rsp);
        chk(rd, 32'h0000_0111);
        en_chk(7'h07);
        axi_wr(PCG_OFS_RUN_GATE_ONE, 32'h0000_0010, rsp);
        en_chk(7'h02);
        axi_wr(PCG_OFS_RUN_GATE_ONE, 32'h0000_0100, rsp);
        en_chk(7'h04);
        periph_req <= '{valid: 1'b1, unit_sel: 7'h04};
        @(negedge clk);
        chk({31'h0, periph_fault}, 32'h0);
        @(posedge clk);
        periph_req <= '{valid: 1'b1, unit_sel: 7'h01};
        @(negedge clk);
        chk({31'h0, periph_fault}, 32'h1);
        @(posedge clk);
        periph_req <= '0;
        axi_wr(PCG_OFS_FAULT_STATUS, 32'h0000_007F, rsp);
    endtask

    task automatic test_deep_gating();
        axi_wr(PCG_OFS_DSLP_GATE_ZERO, 32'hFFFF_FFFF, rsp);
        axi_rd(PCG_OFS_DSLP_GATE_ZERO, rd, rsp);
        chk(rd, 32'h0111_0048);
        axi_wr(PCG_OFS_RUN_GATE_ONE, 32'h0000_0111, rsp);
        power_mode <= PCG_MODE_DEEP;
        en_chk(7'h07);
        axi_wr(PCG_OFS_RUN_CLOCK_CONFIG, 32'h0800_0000, rsp);
        en_chk(7'h78);
        axi_wr(PCG_OFS_DSLP_GATE_ZERO, 32'h0010_0008, rsp);
        en_chk(7'h28);
        axi_wr(PCG_OFS_DSLP_GATE_ZERO, 32'h0001_0000, rsp);
        en_chk(7'h10);
        axi_rd(PCG_OFS_DSLP_GATE_ZERO, rd, rsp);
        chk(rd, 32'h0001_0040);
        axi_wr(PCG_OFS_DSLP_GATE_ZERO, rd & ~PCG_GATE_ZERO_WMASK, rsp);
        axi_rd(PCG_OFS_DSLP_GATE_ZERO, rd, rsp);
        chk(rd, 32'h0000_0040);
        power_mode <= PCG_MODE_RUN;
        en_chk(7'h07);
        power_mode <= PCG_MODE_SLEEP;
        en_chk(7'h00);
        axi_wr(PCG_OFS_SLEEP_GATE_ONE, 32'h0000_0010, rsp);
        en_chk(7'h02);
        power_mode <= PCG_MODE_RUN;
    endtask

    task automatic test_fault_irq();
        axi_wr(PCG_OFS_FAULT_MASK, 32'h0000_0000, rsp);
        periph_req <= '{valid: 1'b1, unit_sel: 7'h40};
        @(negedge clk);
        chk({31'h0, periph_fault}, 32'h1);
        @(posedge clk);
        periph_req <= '0;
        axi_rd(PCG_OFS_FAULT_STATUS, rd, rsp);
        chk(rd, 32'h0000_0040);
        chk({31'h0, irq}, 32'h0);
        axi_wr(PCG_OFS_FAULT_MASK, 32'h0000_0040, rsp);
        chk({31'h0, irq}, 32'h1);
        axi_wr(PCG_OFS_FAULT_STATUS, 32'h0000_0040, rsp);
        chk({31'h0, irq}, 32'h0);
        axi_rd(12'h300, rd, rsp);
        chk(rd, 32'h0000_0000);
        chk({30'h0, rsp}, {30'h0, PCG_RESP_SLVERR});
        axi_wr(12'h300, 32'h0000_0001, rsp);
        chk({30'h0, rsp}, {30'h0, PCG_RESP_SLVERR});
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset_values();
        test_run_gating();
        test_deep_gating();
        test_fault_irq();
        finish_test();
    end

    // Whole run needs well under a thousand cycles; this bound cuts a hung handshake.
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule
